/* psc_dwell.v */
/*
 dwell timer: counts the minimum stay of 2**dwell+1 cycles in a state.
 assumes start_i pulses on the first cycle of a state.
*/
`timescale 1ns/1ps
module psc_dwell #(
	parameter CNT_W = 32
) (
	input  wire       clk_i,
	input  wire       nrst_i,
	input  wire       start_i,
	input  wire [4:0] dwell_i,
	output reg        done_o
);
	reg [CNT_W-1:0] cnt_q;
	wire [CNT_W-1:0] limit;

	// 2**n cycles: done after limit further cycles
	assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << dwell_i) - {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q  <= {CNT_W{1'b0}};
			done_o <= 1'b0;
		end else if (start_i) begin
			cnt_q  <= {CNT_W{1'b0}};
			done_o <= (limit == {CNT_W{1'b0}});
		end else if (!done_o) begin
			cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			done_o <= (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} >= limit);
		end
	end
endmodule

/* psc_map.vh */
/*
 register offsets, field positions, reset values and state codes for
 the power sequence control block. assumes inclusion by psc_top.v only.
*/
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_PERIPH_NUM      8'h06
`define PSC_OFF_WAKE1       8'h10
`define PSC_OFF_WAKE2       8'h14
`define PSC_OFF_AWAKE       8'h18
`define PSC_OFF_STATUS      8'h24
`define PSC_DWELL_HI        20
`define PSC_DWELL_LO        16
`define PSC_BIT_CLKOFF      14
`define PSC_BIT_ANA_MOD     9
`define PSC_BIT_CORE_MOD    8
`define PSC_BIT_IO_EN       5
`define PSC_BIT_PLL_EN      4
`define PSC_BIT_ANA_EN      1
`define PSC_BIT_CORE_EN     0
`define PSC_CFG_MASK        32'h001f_4333
`define PSC_WAKE_RO_MASK    32'h0000_0002
`define PSC_RST_WAKE1       32'h0010_0020
`define PSC_RST_WAKE2       32'h0010_0033
`define PSC_RST_AWAKE       32'h0000_0033
`define PSC_ST_POS          16
`define PSC_PREV_IO_POS     29
`define PSC_PREV_PLL_POS    28
`define PSC_PREV_ANA_POS    25
`define PSC_PREV_CORE_POS   24
`define PSC_CODE_RESET      3'h0
`define PSC_CODE_ASLEEP     3'h1
`define PSC_CODE_WAKE1      3'h2
`define PSC_CODE_WAKE2      3'h3
`define PSC_CODE_AWAIT      3'h4
`define PSC_CODE_AWAKE      3'h5
`define PSC_CODE_SLEEP1     3'h6
`define PSC_CODE_SLEEP2     3'h7
`endif

/* psc_supply_model.sv */
/*
 supply regulators: each good follows its enable after DLY+1 cycles.
 assumes enables come from psc_top; good drops one cycle after its enable falls.
*/
`timescale 1ns/1ps
module psc_supply_model #(
	parameter int DLY = 4
) (
	input wire logic		clk_i,
	input wire logic		nrst_i,
	input wire logic [3:0]	en_i,
	output logic [3:0]		good_o
);
	logic [DLY*4-1:0]	sh_q;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sh_q <= '0;
			good_o <= '0;
		end else begin
			sh_q <= {sh_q[DLY*4-5:0], en_i};
			// a disabled supply reads not good from the next edge on, whatever the shift register holds
			good_o <= en_i & sh_q[DLY*4-1 -: 4];
		end
	end
endmodule

/* psc_sva.sv */
/*
 port checker for psc_top: access answers, status mirror, wake order.
 assumes one clock and the active low asynchronous reset of psc_top.
*/
`timescale 1ns/1ps
module psc_sva (
	input wire logic		clk_i,
	input wire logic		nrst_i,
	input wire logic		req_i,
	input wire logic		req_wr_i,
	input wire logic [7:0]	req_periph_i,
	input wire logic [7:0]	req_reg_i,
	input wire logic [1:0]	req_size_i,
	input wire logic [31:0]	req_wdata_i,
	input wire logic		wake_i,
	input wire logic		sleep_i,
	input wire logic		io_good_i,
	input wire logic		pll_good_i,
	input wire logic		ana_good_i,
	input wire logic		core_good_i,
	input wire logic		ack_o,
	input wire logic		nack_o,
	input wire logic [31:0]	rdata_o,
	input wire logic		io_supply_output_en_o,
	input wire logic		pll_linear_regulator_en_o,
	input wire logic		analogue_converter_en_o,
	input wire logic		core_converter_en_o,
	input wire logic		analogue_converter_pfm_o,
	input wire logic		core_converter_pfm_o,
	input wire logic		tile_clk_off_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire		mine = req_i && req_periph_i == 8'h06;
	wire		hit = req_reg_i inside {8'h10, 8'h14, 8'h18, 8'h24};
	wire		ok_acc = mine && req_size_i == 2'h2 && hit && !(req_wr_i && req_reg_i == 8'h24);
	wire [6:0]	outs = {tile_clk_off_o, analogue_converter_pfm_o, core_converter_pfm_o,
		io_supply_output_en_o, pll_linear_regulator_en_o, analogue_converter_en_o,
		core_converter_en_o};
	sequence s_enter_wake1;
		$rose(io_supply_output_en_o) ##0 !pll_linear_regulator_en_o;
	endsequence
	sequence s_read_status;
		ok_acc && !req_wr_i && req_reg_i == 8'h24;
	endsequence
	a_ack_good_access: assert property (ok_acc |=> ack_o && !nack_o)
		else $error("good access not acked");
	a_nack_bad_access: assert property (mine && !ok_acc |=> nack_o && !ack_o)
		else $error("bad access not nacked");
	a_other_periph_silent: assert property (req_i && !mine |=> !ack_o && !nack_o)
		else $error("foreign access answered");
	a_answer_needs_req: assert property ((ack_o || nack_o) |-> $past(mine))
		else $error("answer without request");
	a_status_mirror_outs: assert property (s_read_status |=>
		{rdata_o[14], rdata_o[9:8], rdata_o[5:4], rdata_o[1:0]} == $past(outs))
		else $error("status does not mirror outputs");
	a_core_after_good: assert property ($rose(core_converter_en_o) |-> $past(io_good_i, 2))
		else $error("left waking one before supply good");
	a_wake_two_together: assert property ($rose(pll_linear_regulator_en_o) |->
		core_converter_en_o && analogue_converter_en_o)
		else $error("waking two supplies not together");
	a_wake_one_dwell: assert property (s_enter_wake1 |-> !core_converter_en_o [*2])
		else $error("waking one left too early");
endmodule
bind psc_top psc_sva u_psc_sva (.*);

/* psc_top.v */
/*
 power sequence control: register file on the peripheral access port and
 the power sequence state machine driving supply enables, modulation and
 the processor clock gate. assumes the interconnect decodes messages into
 a peripheral number, register number and 32-bit data with a one-cycle
 request strobe, and that power-good inputs come from the analogue side.
*/
//
// Overview of operation
// - registers acknowledge only 32-bit accesses to peripheral number 6, other sizes to it get a nack
// - waking states hold the minimum time, then advance when enabled supplies good
// - dwell field 20:16 gives minimum stay of two to that power plus one cycles
// - configuration bit 14 gates off the processor clock
// - bit 9 selects analogue converter modulation, 1 means pulse-frequency
// - bit 8 selects core converter modulation, 1 means pulse-frequency
// - bits 5,4,1,0 enable io, pll, analogue, core; bit 1 read-only in the waking registers
// - waking one resets to dwell 16 with only io supply on
// - waking two resets to dwell 16 with all four supplies on
// - awake register gives settings applied in the awake state
// - status bits 18:16 report the current state code
// - status bits 29,28,25,24 report supplies enabled in previous state
`timescale 1ns/1ps
`include "psc_map.vh"
module psc_top (
	input  wire        clk_i,
	input  wire        nrst_i,
	input  wire        req_i,
	input  wire        req_wr_i,
	input  wire [7:0]  req_periph_i,
	input  wire [7:0]  req_reg_i,
	input  wire [1:0]  req_size_i,
	input  wire [31:0] req_wdata_i,
	input  wire        wake_i,
	input  wire        sleep_i,
	input  wire        io_good_i,
	input  wire        pll_good_i,
	input  wire        ana_good_i,
	input  wire        core_good_i,
	output reg         ack_o,
	output reg         nack_o,
	output reg  [31:0] rdata_o,
	output reg         io_supply_output_en_o,
	output reg         pll_linear_regulator_en_o,
	output reg         analogue_converter_en_o,
	output reg         core_converter_en_o,
	output reg         analogue_converter_pfm_o,
	output reg         core_converter_pfm_o,
	output reg         tile_clk_off_o
);
	localparam [7:0] S_RESET  = 8'h01;
	localparam [7:0] S_ASLEEP = 8'h02;
	localparam [7:0] S_WAKE1  = 8'h04;
	localparam [7:0] S_WAKE2  = 8'h08;
	localparam [7:0] S_AWAIT  = 8'h10;
	localparam [7:0] S_AWAKE  = 8'h20;
	localparam [7:0] S_SLEEP1 = 8'h40;
	localparam [7:0] S_SLEEP2 = 8'h80;
	localparam [1:0] SIZE_32  = 2'h2;

	// external pins pass two flops before use
	reg [5:0] sync1_q;
	reg [5:0] sync2_q;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= {wake_i, sleep_i, io_good_i, pll_good_i, ana_good_i, core_good_i};
			sync2_q <= sync1_q;
		end
	end
	wire wake_s  = sync2_q[5];
	wire sleep_s = sync2_q[4];
	wire [3:0] good_s = sync2_q[3:0];

	reg [31:0] wake1_cfg_q;
	reg [31:0] wake2_cfg_q;
	reg [31:0] awake_cfg_q;
	reg [7:0]  state_q;
	reg [7:0]  state_d;
	reg [31:0] prev_cfg_q;
	reg        enter_q;

	// register access port
	wire hit  = req_i && (req_periph_i == `PSC_PERIPH_NUM) && (req_size_i == SIZE_32);
	wire wr   = hit && req_wr_i;
	wire [31:0] wmask_w = `PSC_CFG_MASK & ~`PSC_WAKE_RO_MASK;

	function [2:0] st_code;
		input [7:0] s;
		begin
			case (s)
				S_ASLEEP: st_code = `PSC_CODE_ASLEEP;
				S_WAKE1:  st_code = `PSC_CODE_WAKE1;
				S_WAKE2:  st_code = `PSC_CODE_WAKE2;
				S_AWAIT:  st_code = `PSC_CODE_AWAIT;
				S_AWAKE:  st_code = `PSC_CODE_AWAKE;
				S_SLEEP1: st_code = `PSC_CODE_SLEEP1;
				S_SLEEP2: st_code = `PSC_CODE_SLEEP2;
				default:  st_code = `PSC_CODE_RESET;
			endcase
		end
	endfunction

	// configuration currently in force
	reg [31:0] cur_cfg;
	always @* begin
		case (state_q)
			S_WAKE1:  cur_cfg = wake1_cfg_q;
			S_WAKE2:  cur_cfg = wake2_cfg_q;
			S_AWAIT:  cur_cfg = awake_cfg_q;
			S_AWAKE:  cur_cfg = awake_cfg_q;
			S_SLEEP1: cur_cfg = wake2_cfg_q;
			S_SLEEP2: cur_cfg = wake1_cfg_q;
			default:  cur_cfg = 32'h0000_0000;
		endcase
	end

	wire [31:0] status_w = (cur_cfg & `PSC_CFG_MASK & ~32'h001f_0000)
		| ({29'h0000_0000, st_code(state_q)} << `PSC_ST_POS)
		| ({31'h0000_0000, prev_cfg_q[`PSC_BIT_IO_EN]} << `PSC_PREV_IO_POS)
		| ({31'h0000_0000, prev_cfg_q[`PSC_BIT_PLL_EN]} << `PSC_PREV_PLL_POS)
		| ({31'h0000_0000, prev_cfg_q[`PSC_BIT_ANA_EN]} << `PSC_PREV_ANA_POS)
		| ({31'h0000_0000, prev_cfg_q[`PSC_BIT_CORE_EN]} << `PSC_PREV_CORE_POS);

	reg [31:0] rd_val;
	reg        rd_ok;
	always @* begin
		rd_ok = 1'b1;
		case (req_reg_i)
			`PSC_OFF_WAKE1:  rd_val = wake1_cfg_q;
			`PSC_OFF_WAKE2:  rd_val = wake2_cfg_q;
			`PSC_OFF_AWAKE:  rd_val = awake_cfg_q;
			`PSC_OFF_STATUS: rd_val = status_w;
			default: begin
				rd_val = 32'h0000_0000;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake1_cfg_q <= `PSC_RST_WAKE1;
			wake2_cfg_q <= `PSC_RST_WAKE2;
			awake_cfg_q <= `PSC_RST_AWAKE;
			ack_o       <= 1'b0;
			nack_o      <= 1'b0;
			rdata_o     <= 32'h0000_0000;
		end else begin
			ack_o   <= 1'b0;
			nack_o  <= 1'b0;
			if (req_i && !hit)
				nack_o <= (req_periph_i == `PSC_PERIPH_NUM);
			if (hit) begin
				if (req_wr_i) begin
					ack_o  <= rd_ok && (req_reg_i != `PSC_OFF_STATUS);
					nack_o <= !(rd_ok && (req_reg_i != `PSC_OFF_STATUS));
				end else begin
					ack_o   <= rd_ok;
					nack_o  <= !rd_ok;
					rdata_o <= rd_val;
				end
			end
			// analogue enable stays read-only in the waking registers
			if (wr && req_reg_i == `PSC_OFF_WAKE1)
				wake1_cfg_q <= (wake1_cfg_q & ~wmask_w) | (req_wdata_i & wmask_w);
			if (wr && req_reg_i == `PSC_OFF_WAKE2)
				wake2_cfg_q <= (wake2_cfg_q & ~wmask_w) | (req_wdata_i & wmask_w);
			if (wr && req_reg_i == `PSC_OFF_AWAKE)
				awake_cfg_q <= req_wdata_i & `PSC_CFG_MASK;
		end
	end

	// dwell timing for the waking states
	wire [4:0] dwell_w = (state_q == S_WAKE2) ? wake2_cfg_q[`PSC_DWELL_HI:`PSC_DWELL_LO]
		: wake1_cfg_q[`PSC_DWELL_HI:`PSC_DWELL_LO];
	wire dwell_done;
	psc_dwell #(
		.CNT_W(32)
	) u_dwell (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.start_i (enter_q),
		.dwell_i (dwell_w),
		.done_o  (dwell_done)
	);

	// every enabled supply must report good; disabled ones are ignored
	wire [3:0] en_w = {cur_cfg[`PSC_BIT_IO_EN], cur_cfg[`PSC_BIT_PLL_EN],
		cur_cfg[`PSC_BIT_ANA_EN], cur_cfg[`PSC_BIT_CORE_EN]};
	wire all_good = &(good_s | ~en_w);
	wire may_go   = dwell_done && !enter_q && all_good;

	always @* begin
		case (state_q)
			S_RESET:  state_d = S_ASLEEP;
			S_ASLEEP: state_d = wake_s ? S_WAKE1 : S_ASLEEP;
			S_WAKE1:  state_d = may_go ? S_WAKE2 : S_WAKE1;
			S_WAKE2:  state_d = may_go ? S_AWAIT : S_WAKE2;
			S_AWAIT:  state_d = all_good ? S_AWAKE : S_AWAIT;
			S_AWAKE:  state_d = sleep_s ? S_SLEEP1 : S_AWAKE;
			S_SLEEP1: state_d = S_SLEEP2;
			S_SLEEP2: state_d = S_ASLEEP;
			default:  state_d = S_RESET;
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q    <= S_RESET;
			enter_q    <= 1'b0;
			prev_cfg_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			enter_q <= (state_d != state_q);
			if (state_d != state_q)
				prev_cfg_q <= cur_cfg;
		end
	end

	// outputs registered from the configuration of the next state
	reg [31:0] nxt_cfg;
	always @* begin
		case (state_d)
			S_WAKE1:  nxt_cfg = wake1_cfg_q;
			S_WAKE2:  nxt_cfg = wake2_cfg_q;
			S_AWAIT:  nxt_cfg = awake_cfg_q;
			S_AWAKE:  nxt_cfg = awake_cfg_q;
			S_SLEEP1: nxt_cfg = wake2_cfg_q;
			S_SLEEP2: nxt_cfg = wake1_cfg_q;
			default:  nxt_cfg = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			io_supply_output_en_o     <= 1'b0;
			pll_linear_regulator_en_o <= 1'b0;
			analogue_converter_en_o   <= 1'b0;
			core_converter_en_o       <= 1'b0;
			analogue_converter_pfm_o  <= 1'b0;
			core_converter_pfm_o      <= 1'b0;
			tile_clk_off_o            <= 1'b0;
		end else begin
			io_supply_output_en_o     <= nxt_cfg[`PSC_BIT_IO_EN];
			pll_linear_regulator_en_o <= nxt_cfg[`PSC_BIT_PLL_EN];
			analogue_converter_en_o   <= nxt_cfg[`PSC_BIT_ANA_EN];
			core_converter_en_o       <= nxt_cfg[`PSC_BIT_CORE_EN];
			analogue_converter_pfm_o  <= nxt_cfg[`PSC_BIT_ANA_MOD];
			core_converter_pfm_o      <= nxt_cfg[`PSC_BIT_CORE_MOD];
			tile_clk_off_o            <= nxt_cfg[`PSC_BIT_CLKOFF];
		end
	end
endmodule

/* tb_top.sv */
/*
 testbench for psc_top: register access, refusals, wake and sleep runs.
 assumes the supply model answers every enable with a good.
*/
`timescale 1ns/1ps
module tb_top;
	logic		clk_i = 0, nrst_i = 0, req_i = 0, req_wr_i = 0, wake_i = 0, sleep_i = 0;
	logic [7:0]	req_periph_i = 8'h06, req_reg_i = 8'h00;
	logic [1:0]	req_size_i = 2'h2;
	logic [31:0]	req_wdata_i = 32'h0, rdata_o;
	logic		io_good_i, pll_good_i, ana_good_i, core_good_i, ack_o, nack_o;
	logic		io_supply_output_en_o, pll_linear_regulator_en_o, analogue_converter_en_o;
	logic		core_converter_en_o, analogue_converter_pfm_o, core_converter_pfm_o;
	logic		tile_clk_off_o;
	int		fail_count = 0, comparisons = 0;
	wire [6:0]	outs = {tile_clk_off_o, analogue_converter_pfm_o, core_converter_pfm_o,
		io_supply_output_en_o, pll_linear_regulator_en_o, analogue_converter_en_o,
		core_converter_en_o};
	psc_top u_psc_top (.*);
	psc_supply_model u_psc_supply_model (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(outs[3:0]),
		.good_o({io_good_i, pll_good_i, ana_good_i, core_good_i}));
	initial forever #50 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [7:0] rg, input logic [1:0] sz,
		input logic [31:0] d, output logic [1:0] an);
		@(negedge clk_i);
		{req_i, req_wr_i, req_reg_i, req_size_i, req_wdata_i} = {1'b1, wr, rg, sz, d};
		@(negedge clk_i);
		// the answer stands for one cycle after the taking edge, so look now
		an = {ack_o, nack_o};
		req_i = 0;
	endtask
	task automatic rd(input logic [7:0] rg, input logic [31:0] m, input logic [31:0] exp);
		logic [1:0] an;
		acc(0, rg, 2'h2, 32'h0, an);
		chk({30'h0, an}, 32'h2);
		chk(rdata_o & m, exp);
	endtask
	task automatic wt(input logic [7:0] rg, input logic [31:0] d);
		logic [1:0] an;
		acc(1, rg, 2'h2, d, an);
		chk({30'h0, an}, 32'h2);
	endtask
	task automatic wait_out(input int k, input logic v);
		for (int n = 0; n < 300 && outs[k] !== v; n++) @(negedge clk_i);
		chk({31'h0, outs[k]}, {31'h0, v});
	endtask
	task automatic complete_run;
		$display("TB: comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		logic [1:0] an;
		repeat (6) @(negedge clk_i);
		nrst_i = 1;
		rd(8'h10, 32'hffff_ffff, 32'h0010_0020);
		rd(8'h14, 32'hffff_ffff, 32'h0010_0033);
		rd(8'h18, 32'hffff_ffff, 32'h0000_0033);
		rd(8'h24, 32'h0007_0000, 32'h0001_0000);
		$display("TB: reset values done");
		acc(0, 8'h10, 2'h1, 32'h0, an);
		chk({30'h0, an}, 32'h1);
		acc(0, 8'h20, 2'h2, 32'h0, an);
		chk({30'h0, an}, 32'h1);
		acc(1, 8'h24, 2'h2, 32'hffff_ffff, an);
		chk({30'h0, an}, 32'h1);
		req_periph_i = 8'h05;
		acc(1, 8'h10, 2'h2, 32'h0, an);
		chk({30'h0, an}, 32'h0);
		req_periph_i = 8'h06;
		rd(8'h10, 32'hffff_ffff, 32'h0010_0020);
		wt(8'h10, 32'hffff_ffff);
		rd(8'h10, 32'hffff_ffff, 32'h001f_4331);
		wt(8'h10, 32'h0002_0020);
		wt(8'h14, 32'h0001_4331);
		rd(8'h14, 32'hffff_ffff, 32'h0001_4333);
		wt(8'h18, 32'h0000_0031);
		$display("TB: register access done");
		wake_i = 1;
		wait_out(3, 1);
		chk({25'h0, outs}, 32'h08);
		wait_out(0, 1);
		chk({25'h0, outs}, 32'h7f);
		wait_out(1, 0);
		repeat (10) @(negedge clk_i);
		chk({25'h0, outs}, 32'h0d);
		rd(8'h24, 32'h0007_4333, 32'h0005_0031);
		rd(8'h24, 32'h3300_0000, 32'h3100_0000);
		$display("TB: wake sequence done");
		wake_i = 0;
		sleep_i = 1;
		wait_out(3, 0);
		rd(8'h24, 32'h0007_4333, 32'h0001_0000);
		rd(8'h24, 32'h3300_0000, 32'h2000_0000);
		$display("TB: sleep sequence done");
		complete_run();
	end
	initial begin
		#(20000 * 100);
		fail_count++;
		complete_run();
	end
endmodule
